// ### include/exposure_defs.svh
`ifndef EXPOSURE_DEFS_SVH
`define EXPOSURE_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IDX_STATUS      8'h00
`define IDX_ABS_MAX     8'h09
`define IDX_RAW_SET     8'h0D
`define IDX_RAW_MIN     8'h11
`define IDX_RAW_MAX     8'h15
`define ADDR_W          8
`define IDX_W           8

// ----------------------------------------------------------------
// field layout and values
// ----------------------------------------------------------------
`define RAW_W           24
`define WORD_W          32
`define PAD_W           8
`define STAT_W          8
`define STAT_NONE       8'h00
`define STAT_OK         8'h01
`define STAT_RANGE      8'h80
`define RAW_SET_RESET   24'h0004B0
`define RAW_MIN_RESET   24'h000001
`define RAW_MAX_RESET   24'hFFFFFF
`define ABS_MAX_RESET   32'h00000000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define EXP_STEP_NS     100
`define EXP_STEP_CYCLES ((`EXP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W           32

`endif

// ### include/exposure_pkg.sv
package exposure_pkg;

  typedef logic [23:0] raw_t;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  stat_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXPOSE
  } exposure_state_t;

endpackage

// ### rtl/exposure_time_raw_fields.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "exposure_defs.svh"

// Overview of operation
// R1: the float maximum exposure is read-only and follows the related settings.
// R2: a write to the raw exposure field sets the exposure used by the timer.
// R3: exposure length is the raw value times a 0.1 us step; the code first clamps the raw value to the raw limits.
// R4: raw bytes are low, mid, high of a 24-bit value; the top byte is zero.
// R5: software reads the raw limits before writing a raw exposure value.
// R6: the raw minimum field is read-only and holds the smallest raw value allowed.
// R7: the raw maximum field is read-only and holds the largest raw value allowed.
// R8: the raw limits are refreshed every cycle from the related settings.
// R9: the raw minimum is little-endian 24 bits with a zero top byte.
// R10: the raw maximum uses the same byte order with a zero top byte.
// R11: status reads 0x01 when valid and 0x80 when the setting is out of range.
// R12: writes to the read-only limit fields are ignored.
module exposure_time_raw_fields
  import exposure_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [`ADDR_W-1:0]   i_addr,
  input  wire logic [`WORD_W-1:0]   i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [`WORD_W-1:0]   o_rdata,
  input  wire logic                 i_csr_present,
  input  wire logic [`RAW_W-1:0]    i_cfg_raw_min,
  input  wire logic [`RAW_W-1:0]    i_cfg_raw_max,
  input  wire logic [`WORD_W-1:0]   i_cfg_abs_max,
  input  wire logic                 i_expose_start,
  output logic                      o_exposing,
  output logic                      o_expose_done,
  output logic      [`RAW_W-1:0]    o_exposure_raw,
  output logic      [`STAT_W-1:0]   o_status
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] addr,
                                    input logic [`IDX_W-1:0]  idx);
    addr_hit = (addr == idx);
  endfunction

  function automatic word_t pack_raw(input raw_t value);
    pack_raw = {{`PAD_W{1'b0}}, value};
  endfunction

  function automatic logic in_range(input raw_t value,
                                    input raw_t lo,
                                    input raw_t hi);
    in_range = (value >= lo) && (value <= hi);
  endfunction

  function automatic raw_t clamp_raw(input raw_t value,
                                     input raw_t lo,
                                     input raw_t hi);
    if (value < lo) begin
      clamp_raw = lo;
    end else if (value > hi) begin
      clamp_raw = hi;
    end else begin
      clamp_raw = value;
    end
  endfunction

  function automatic logic [`CNT_W-1:0] cycles_of(input raw_t value);
    logic [`CNT_W-1:0] steps;
    steps     = {{`PAD_W{1'b0}}, value};
    cycles_of = steps * `CNT_W'(`EXP_STEP_CYCLES);
  endfunction

  function automatic word_t read_sel(input logic [`ADDR_W-1:0] addr,
                                     input stat_t             status,
                                     input word_t             abs_max,
                                     input raw_t              raw_set,
                                     input raw_t              raw_min,
                                     input raw_t              raw_max);
    if (addr_hit(addr, `IDX_STATUS)) begin
      read_sel = {{(`WORD_W-`STAT_W){1'b0}}, status};
    end else if (addr_hit(addr, `IDX_ABS_MAX)) begin
      read_sel = abs_max;
    end else if (addr_hit(addr, `IDX_RAW_SET)) begin
      read_sel = pack_raw(raw_set);
    end else if (addr_hit(addr, `IDX_RAW_MIN)) begin
      read_sel = pack_raw(raw_min);
    end else if (addr_hit(addr, `IDX_RAW_MAX)) begin
      read_sel = pack_raw(raw_max);
    end else begin
      read_sel = {`WORD_W{1'b0}};
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  raw_t              raw_set_q;
  raw_t              raw_set_d;
  raw_t              raw_min_q;
  raw_t              raw_max_q;
  word_t             abs_max_q;
  stat_t             status_q;
  stat_t             status_d;
  word_t             rdata_q;
  word_t             rdata_d;
  exposure_state_t   state_q;
  exposure_state_t   state_d;
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cnt_d;
  logic              done_q;
  logic              done_d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic hit_status  = addr_hit(i_addr, `IDX_STATUS);
  wire logic hit_abs_max = addr_hit(i_addr, `IDX_ABS_MAX);
  wire logic hit_raw_set = addr_hit(i_addr, `IDX_RAW_SET);
  wire logic hit_raw_min = addr_hit(i_addr, `IDX_RAW_MIN);
  wire logic hit_raw_max = addr_hit(i_addr, `IDX_RAW_MAX);

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // R2: raw setting write
  wire logic wr_raw_set  = i_wr && hit_raw_set;

  // R12: limit fields have no write path at all
  wire logic wr_ignored  = i_wr && (hit_raw_min || hit_raw_max || hit_abs_max || hit_status);

  // R4: top byte of the written word is dropped
  wire raw_t wr_raw      = i_wdata[`RAW_W-1:0];

  // ----------------------------------------------------------------
  // raw exposure setting
  // ----------------------------------------------------------------
  always_comb begin
    raw_set_d = raw_set_q;
    if (wr_raw_set) begin
      raw_set_d = wr_raw;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      raw_set_q <= `RAW_SET_RESET;
    end else begin
      raw_set_q <= raw_set_d;
    end
  end

  // ----------------------------------------------------------------
  // limits
  // ----------------------------------------------------------------
  // R8: limits follow the related settings every cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      raw_min_q <= `RAW_MIN_RESET;
      raw_max_q <= `RAW_MAX_RESET;
    end else begin
      // R6: minimum only from config
      raw_min_q <= i_cfg_raw_min;
      // R7: maximum only from config
      raw_max_q <= i_cfg_raw_max;
    end
  end

  // R1: float maximum tracks configuration
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      abs_max_q <= `ABS_MAX_RESET;
    end else begin
      abs_max_q <= i_cfg_abs_max;
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  // judged on stored value, so a limit change can also flag it
  wire logic set_in_range = in_range(raw_set_q, raw_min_q, raw_max_q);

  // R11: status encoding
  always_comb begin
    if (!i_csr_present) begin
      status_d = `STAT_NONE;
    end else if (set_in_range) begin
      status_d = `STAT_OK;
    end else begin
      status_d = `STAT_RANGE;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_q <= `STAT_NONE;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // R4: raw fields read with a zero top byte
  // R9: minimum packed little-endian
  // R10: maximum packed the same way
  wire word_t rd_mux = read_sel(i_addr, status_q, abs_max_q, raw_set_q, raw_min_q, raw_max_q);

  // data only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = {`WORD_W{1'b0}};
    if (i_rd) begin
      rdata_d = rd_mux;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= {`WORD_W{1'b0}};
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // exposure timer
  // ----------------------------------------------------------------
  // R5: clamp guards against software skipping the limit check
  wire raw_t eff_raw = clamp_raw(raw_set_q, raw_min_q, raw_max_q);

  // R3: length in cycles from raw steps
  wire logic [`CNT_W-1:0] eff_cycles = cycles_of(eff_raw);

  wire logic cnt_last = (cnt_q <= `CNT_W'(1));

  // refused while busy
  wire logic start_ok = i_expose_start && (state_q == ST_IDLE);

  // length is latched at start so a write mid-exposure waits
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          if (eff_cycles == {`CNT_W{1'b0}}) begin
            done_d = 1'b1;
          end else begin
            cnt_d   = eff_cycles;
            state_d = ST_EXPOSE;
          end
        end
      end
      ST_EXPOSE: begin
        if (cnt_last) begin
          cnt_d   = {`CNT_W{1'b0}};
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - `CNT_W'(1);
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = {`CNT_W{1'b0}};
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= {`CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // R3: one-cycle end pulse
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rdata        = rdata_q;
  assign o_exposing     = (state_q == ST_EXPOSE);
  assign o_expose_done  = done_q;
  assign o_exposure_raw = raw_set_q;
  assign o_status       = status_q;

  // writes to read-only fields fall through with no effect
  wire logic unused_ok = wr_ignored ^ (|i_wdata[`WORD_W-1:`RAW_W]);

endmodule

// ### dv/exposure_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------
// port-level checks
// ------------------------------------------------
module exposure_checks (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        i_csr_present,
  input  wire logic [23:0] i_cfg_raw_min,
  input  wire logic [23:0] i_cfg_raw_max,
  input  wire logic [31:0] i_cfg_abs_max,
  input  wire logic        o_exposing,
  input  wire logic        o_expose_done,
  input  wire logic [23:0] o_exposure_raw,
  input  wire logic [7:0]  o_status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_wr; i_wr && i_addr == 8'h0D |=>
    {8'h00, o_exposure_raw} == ($past(i_wdata) & 32'h00FFFFFF); endproperty
  a_wr: assert property (p_wr) else $error("raw setting not stored");
  property p_set_rd; i_rd && i_addr == 8'h0D |=> o_rdata == {8'h00, $past(o_exposure_raw)};
  endproperty
  a_set_rd: assert property (p_set_rd) else $error("raw setting read wrong");
  property p_min_rd; i_rd && i_addr == 8'h11 && $stable(i_cfg_raw_min) && !$past(i_sys_rst)
    |=> o_rdata == {8'h00, $past(i_cfg_raw_min)}; endproperty
  a_min_rd: assert property (p_min_rd) else $error("raw minimum read wrong");
  property p_max_rd; i_rd && i_addr == 8'h15 && $stable(i_cfg_raw_max) && !$past(i_sys_rst)
    |=> o_rdata == {8'h00, $past(i_cfg_raw_max)}; endproperty
  a_max_rd: assert property (p_max_rd) else $error("raw maximum read wrong");
  property p_abs_rd; i_rd && i_addr == 8'h09 && $stable(i_cfg_abs_max) && !$past(i_sys_rst)
    |=> o_rdata == $past(i_cfg_abs_max); endproperty
  a_abs_rd: assert property (p_abs_rd) else $error("float maximum read wrong");
  property p_stat_off; !i_csr_present [*3] |-> o_status == 8'h00; endproperty
  a_stat_off: assert property (p_stat_off) else $error("status not cleared");
  // limits and setting must settle before the judgement is trusted
  property p_stat_val; (!i_sys_rst && i_csr_present && $stable(o_exposure_raw)
    && $stable(i_cfg_raw_min) && $stable(i_cfg_raw_max)) [*3] |-> o_status ==
    ((o_exposure_raw < i_cfg_raw_min || o_exposure_raw > i_cfg_raw_max) ? 8'h80 : 8'h01);
  endproperty
  a_stat_val: assert property (p_stat_val) else $error("status judgement wrong");
  property p_ro; i_wr && i_addr != 8'h0D |=> $stable(o_exposure_raw); endproperty
  a_ro: assert property (p_ro) else $error("read-only write took effect");
  property p_done; $fell(o_exposing) |-> o_expose_done; endproperty
  a_done: assert property (p_done) else $error("exposure end without done");
  c_wr: cover property (i_wr && i_addr == 8'h0D);
  c_range: cover property (o_status == 8'h80);
  c_done: cover property (o_expose_done);
endmodule

bind exposure_time_raw_fields exposure_checks i_chk (
  .i_clk          (i_clk),
  .i_sys_rst      (i_sys_rst),
  .i_addr         (i_addr),
  .i_wdata        (i_wdata),
  .i_wr           (i_wr),
  .i_rd           (i_rd),
  .o_rdata        (o_rdata),
  .i_csr_present  (i_csr_present),
  .i_cfg_raw_min  (i_cfg_raw_min),
  .i_cfg_raw_max  (i_cfg_raw_max),
  .i_cfg_abs_max  (i_cfg_abs_max),
  .o_exposing     (o_exposing),
  .o_expose_done  (o_expose_done),
  .o_exposure_raw (o_exposure_raw),
  .o_status       (o_status)
);

// ### dv/exposure_time_raw_fields_test.sv
`timescale 1ns/1ps
// ------------------------------------------------
// bench
// ------------------------------------------------
module exposure_time_raw_fields_test;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
  logic        i_csr_present = 1'b1, i_expose_start = 1'b0, o_exposing, o_expose_done;
  logic [7:0]  i_addr = 8'h00, o_status;
  logic [31:0] i_wdata = 32'h0, i_cfg_abs_max = 32'h3F800000, o_rdata, v, a, exp_q[$];
  logic [23:0] i_cfg_raw_min = 24'h000002, i_cfg_raw_max = 24'h000064, o_exposure_raw, r;
  int          n_mismatch = 0, num_checks = 0, n;
  integer      seed = 32'h7126e90b;
  logic [7:0]  ro_addr [4] = '{8'h00, 8'h09, 8'h11, 8'h15};
  exposure_time_raw_fields i_exposure_time_raw_fields (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_csr_present  (i_csr_present),
    .i_cfg_raw_min  (i_cfg_raw_min),
    .i_cfg_raw_max  (i_cfg_raw_max),
    .i_cfg_abs_max  (i_cfg_abs_max),
    .i_expose_start (i_expose_start),
    .o_exposing     (o_exposing),
    .o_expose_done  (o_expose_done),
    .o_exposure_raw (o_exposure_raw),
    .o_status       (o_status)
  );
  initial forever #50 i_clk = ~i_clk;
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [31:0] e);
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic st(logic [7:0] e);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check("status", {24'h0, o_status}, {24'h0, e});
  endtask
  // bounded wait: a hang counts as a mismatch and ends the run
  task automatic expose(int exp_n);
    @(posedge i_clk);
    i_expose_start <= 1'b1;
    @(posedge i_clk);
    i_expose_start <= 1'b0;
    n = 0;
    for (int k = 0; k < 300; k++) begin
      @(negedge i_clk);
      if (o_expose_done === 1'b1) break;
      if (o_exposing === 1'b1) n++;
      if (k == 299) begin
        n_mismatch++;
        test_done();
      end
    end
    check("exposure cycles", n, exp_n);
  endtask
  always @(negedge i_clk) begin
    if (rd_seen) check("rdata", o_rdata, exp_q.pop_front());
    rd_seen = i_rd;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd(8'h0D, 32'h000004B0);
    rd(8'h11, 32'h00000002);
    rd(8'h15, 32'h00000064);
    rd(8'h09, 32'h3F800000);
    wr(8'h0D, 32'hAB000003);
    rd(8'h0D, 32'h00000003);
    st(8'h01);
    rd(8'h00, 32'h00000001);
    expose(3);
    for (int i = 0; i < 4; i++) begin
      wr(ro_addr[i], 32'hFFFFFFFF);
    end
    rd(8'h0D, 32'h00000003);
    rd(8'h11, 32'h00000002);
    rd(8'h15, 32'h00000064);
    rd(8'h34, 32'h00000000);
    rd(8'h0E, 32'h00000000);
    wr(8'h0D, 32'h00000001);
    st(8'h80);
    expose(2);
    wr(8'h0D, 32'h000000C8);
    st(8'h80);
    expose(100);
    @(posedge i_clk);
    i_cfg_raw_min <= 24'h000000;
    wr(8'h0D, 32'h00000000);
    st(8'h01);
    expose(0);
    @(posedge i_clk);
    i_csr_present <= 1'b0;
    st(8'h00);
    @(posedge i_clk);
    i_csr_present <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      r = 24'($random(seed));
      v = $random(seed);
      a = $random(seed);
      i_cfg_raw_min <= {16'h0000, r[7:0]};
      i_cfg_raw_max <= {8'h00, r[23:8]};
      i_cfg_abs_max <= a;
      rd(8'h11, {24'h000000, r[7:0]});
      rd(8'h15, {16'h0000, r[23:8]});
      wr(8'h0D, {8'h00, 8'h00, v[15:0]});
      rd(8'h0D, {16'h0000, v[15:0]});
      rd(8'h09, a);
      st((v[15:0] < r[7:0] || v[15:0] > r[23:8]) ? 8'h80 : 8'h01);
    end
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(8'h0D, 32'h000004B0);
    repeat (3) @(posedge i_clk);
    test_done();
  end
endmodule
